// *** hdl/ext_mem_wait_bank_paging.v ***
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "ext_mem_consts.vh"
module ext_mem_wait_bank_paging (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        acc_req,
  input  wire [1:0]  acc_space,
  input  wire [22:0] acc_addr,
  input  wire        acc_far,
  input  wire [6:0]  acc_far_page,
  input  wire        vec_req,
  input  wire [4:0]  vec_num,
  input  wire        vec_is_reset,
  input  wire        ram_overlay_enable,
  input  wire        rom_select_input,
  input  wire        ready_in,
  input  wire        interrupt_ack_output_in,
  output reg         acc_done,
  output reg         acc_external,
  output reg         acc_onchip_ram,
  output reg         acc_onchip_rom,
  output reg  [22:0] ext_addr,
  output reg  [22:0] vec_addr,
  output reg         memory_strobe_n,
  output reg         output_clock_pin,
  output reg         interrupt_ack_output_n,
  output reg         host_bus_keeper,
  output reg         data_bus_keeper,
  output reg         wait_clk_enable
);
  // ************************************************
  // space codes and sequencer states
  // ************************************************
  localparam SP_PROG = 2'h0;
  localparam SP_DATA = 2'h1;
  localparam SP_IO   = 2'h2;
  localparam ST_IDLE  = 3'h0;
  localparam ST_SWAP  = 3'h1;
  localparam ST_START = 3'h2;
  localparam ST_WAIT  = 3'h3;
  localparam ST_TRAIL = 3'h4;

  // ************************************************
  // registers
  // ************************************************
  reg  [6:0]  program_page_register;  // current program page
  reg  [15:0] wait_state_fields_reg;  // per-region wait fields
  reg         wait_multiplier_bit;    // doubles wait counts
  reg         consecutive_switching;  // bank mode
  reg  [1:0]  output_clock_divider;   // clock divide field
  reg         ack_output_disable;     // acknowledge suppress
  reg  [8:0]  vector_page_pointer;    // vector page pointer
  reg  [2:0]  state;                  // external cycle state
  reg  [3:0]  wait_cnt;               // wait countdown
  reg  [1:0]  div_cnt;                // clock divider count
  reg         last_bank;              // bit 15 of last address
  reg         last_prog;              // last access was program
  reg  [6:0]  last_page;              // page of last external memory access
  reg         seen_access;            // a previous access exists

  // ************************************************
  // apb decode
  // ************************************************
  wire [7:0] idx      = paddr[9:2];  // word index
  wire       apb_wr   = psel & penable & pwrite & pready;
  wire       apb_rd   = psel & ~penable & ~pwrite;
  wire [15:0] bank_rd = {consecutive_switching, output_clock_divider, ack_output_disable,
                         9'h000, host_bus_keeper, data_bus_keeper, 1'b0};

  // read mux; unmapped words read zero with error
  reg [31:0] next_rdata;
  reg        next_err;
  always @* begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (idx == `IDX_PAGE) begin
      next_rdata = {25'h0000000, program_page_register};
    end else if (idx == `IDX_WAIT_FIELDS) begin
      next_rdata = {16'h0000, wait_state_fields_reg};
    end else if (idx == `IDX_BANK_CTRL) begin
      next_rdata = {16'h0000, bank_rd};
    end else if (idx == `IDX_WAIT_CTRL) begin
      next_rdata = {31'h00000000, wait_multiplier_bit};
    end else if (idx == `IDX_VEC_PTR) begin
      next_rdata = {23'h000000, vector_page_pointer};
    end else begin
      next_err = 1'b1;
    end
  end

  // apb answer: pready is registered from the setup cycle and rises in the first access cycle, so access ends after one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & next_err;
      if (apb_rd) begin
        prdata <= next_rdata;
      end
    end
  end

  // ************************************************
  // register writes and far page updates
  // ************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_page_register <= `RST_PAGE;
      wait_state_fields_reg <= `RST_WAIT_FIELDS;
      wait_multiplier_bit   <= 1'b0;
      consecutive_switching <= 1'b1;
      output_clock_divider  <= `RST_DIV;
      ack_output_disable    <= 1'b1;
      host_bus_keeper       <= 1'b0;
      data_bus_keeper       <= 1'b0;
      vector_page_pointer   <= `RST_VEC_PTR;
    end else begin
      if (acc_far && state == ST_IDLE) begin
        program_page_register <= acc_far_page;
      end else if (apb_wr && idx == `IDX_PAGE) begin
        program_page_register <= pwdata[6:0];
      end
      if (apb_wr && idx == `IDX_WAIT_FIELDS) begin
        wait_state_fields_reg <= pwdata[15:0];
      end
      if (apb_wr && idx == `IDX_WAIT_CTRL) begin
        wait_multiplier_bit <= pwdata[0];
      end
      if (apb_wr && idx == `IDX_VEC_PTR) begin
        vector_page_pointer <= pwdata[8:0];
      end
      if (apb_wr && idx == `IDX_BANK_CTRL) begin
        consecutive_switching <= pwdata[`BC_CONSECUTIVE_SWITCHING_BIT];
        output_clock_divider  <= pwdata[`BC_DIV_HI:`BC_DIV_LO];
        ack_output_disable    <= pwdata[`BC_ACKOFF_BIT];
        host_bus_keeper       <= pwdata[`BC_HKEEP_BIT];
        data_bus_keeper       <= pwdata[`BC_DKEEP_BIT];
      end
    end
  end

  // ************************************************
  // address decode
  // ************************************************
  reg        dec_ram;    // on-chip ram hit
  reg        dec_rom;    // on-chip rom hit
  reg [22:0] dec_addr;   // physical address
  reg [2:0]  dec_field;  // selected wait field
  always @* begin
    dec_ram   = 1'b0;
    dec_rom   = 1'b0;
    dec_addr  = acc_addr;
    dec_field = 3'h0;
    if (acc_space == SP_PROG) begin
      dec_addr = {program_page_register, acc_addr[15:0]};
      if (acc_far) begin
        dec_addr = acc_addr;
      end
      if (ram_overlay_enable && !dec_addr[15]) begin
        dec_ram  = 1'b1;
        dec_addr = {7'h00, dec_addr[15:0]};
      end else if (!rom_select_input && dec_addr[22:16] == 7'h00 && dec_addr[15:0] >= `ROM_BASE) begin
        dec_rom = 1'b1;
      end
      if (wait_state_fields_reg[`WF_RANGE_BIT]) begin
        dec_field = dec_addr[22] ? wait_state_fields_reg[`WF_PHI_HI:`WF_PHI_LO]
                                 : wait_state_fields_reg[`WF_PLO_HI:`WF_PLO_LO];
      end else begin
        dec_field = dec_addr[15] ? wait_state_fields_reg[`WF_PHI_HI:`WF_PHI_LO]
                                 : wait_state_fields_reg[`WF_PLO_HI:`WF_PLO_LO];
      end
    end else if (acc_space == SP_DATA) begin
      dec_addr = {7'h00, acc_addr[15:0]};
      dec_ram  = (acc_addr[15:0] <= `ONCHIP_DATA_TOP);
      dec_field = wait_state_fields_reg[`WF_DHI_HI:`WF_DHI_LO];
    end else begin
      dec_addr  = {7'h00, acc_addr[15:0]};
      dec_field = wait_state_fields_reg[`WF_IO_HI:`WF_IO_LO];
    end
  end

  // wait count, doubled by multiplier
  wire [3:0] wait_load = wait_multiplier_bit ? {dec_field, 1'b0} : {1'b0, dec_field};
  wire       is_ext    = ~dec_ram & ~dec_rom;
  wire       mem_space = (acc_space != SP_IO);
  // bank change: new bank, space switch, or new program page
  wire bank_change = seen_access & mem_space &
    ((last_bank != dec_addr[15]) | (last_prog != (acc_space == SP_PROG)) |
     ((acc_space == SP_PROG) & (last_page != dec_addr[22:16])));

  // ************************************************
  // external cycle sequencer
  // ************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state           <= ST_IDLE;
      wait_cnt        <= 4'h0;
      memory_strobe_n <= 1'b1;
      acc_done        <= 1'b0;
      acc_external    <= 1'b0;
      acc_onchip_ram  <= 1'b0;
      acc_onchip_rom  <= 1'b0;
      ext_addr        <= 23'h000000;
      last_bank       <= 1'b0;
      last_prog       <= 1'b0;
      last_page       <= 7'h00;
      seen_access     <= 1'b0;
    end else begin
      acc_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          memory_strobe_n <= 1'b1;
          if (acc_req && !acc_done) begin
            acc_external   <= is_ext;
            acc_onchip_ram <= dec_ram;
            acc_onchip_rom <= dec_rom;
            if (!is_ext) begin
              acc_done <= 1'b1;
            end else begin
              ext_addr <= dec_addr;
              wait_cnt <= wait_load;
              if (mem_space) begin
                last_bank   <= dec_addr[15];
                last_prog   <= (acc_space == SP_PROG);
                last_page   <= dec_addr[22:16];
                seen_access <= 1'b1;
              end
              if (mem_space && consecutive_switching) begin
                state <= ST_START;
              end else if (bank_change) begin
                state <= ST_SWAP;
              end else begin
                memory_strobe_n <= 1'b0;
                state <= ST_WAIT;
              end
            end
          end
        end
        ST_SWAP: begin
          memory_strobe_n <= 1'b0;  // strobe held off one cycle
          state <= ST_WAIT;
        end
        ST_START: begin
          memory_strobe_n <= 1'b0;
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
          end else if (ready_in) begin
            memory_strobe_n <= 1'b1;
            if (consecutive_switching && mem_space) begin
              state <= ST_TRAIL;
            end else begin
              acc_done <= 1'b1;
              state <= ST_IDLE;
            end
          end
        end
        ST_TRAIL: begin
          acc_done <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************
  // vectors, clock out, ack, gating
  // ************************************************
  wire [2:0] f_io  = wait_state_fields_reg[`WF_IO_HI:`WF_IO_LO];
  wire [2:0] f_dhi = wait_state_fields_reg[`WF_DHI_HI:`WF_DHI_LO];
  wire [2:0] f_phi = wait_state_fields_reg[`WF_PHI_HI:`WF_PHI_LO];
  wire [2:0] f_plo = wait_state_fields_reg[`WF_PLO_HI:`WF_PLO_LO];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_addr               <= 23'h000000;
      div_cnt                <= 2'h0;
      output_clock_pin       <= 1'b0;
      interrupt_ack_output_n <= 1'b1;
      wait_clk_enable        <= 1'b1;
    end else begin
      if (vec_req) begin
        // reset vector fixed; others on current pointer page
        vec_addr <= vec_is_reset ? {7'h00, `RST_VEC_PTR, 7'h00}
                                 : {program_page_register, vector_page_pointer, vec_num, 2'h0};
      end
      if (div_cnt >= output_clock_divider) begin
        div_cnt <= 2'h0;
      end else begin
        div_cnt <= div_cnt + 2'h1;
      end
      // compare at three bits: divide-by-four must not wrap the half-period sum to zero
      output_clock_pin <= (output_clock_divider == 2'h0) ? ~output_clock_pin
                                                          : ({1'b0, div_cnt} <
                                                             (({1'b0, output_clock_divider} + 3'h1) >> 1));
      interrupt_ack_output_n <= ack_output_disable ? 1'b1 : ~interrupt_ack_output_in;
      wait_clk_enable <= (f_io != 3'h0) | (f_dhi != 3'h0) | (f_phi != 3'h0) | (f_plo != 3'h0);
    end
  end
endmodule
`default_nettype wire

// *** hdl/ext_mem_consts.vh ***
`ifndef EXT_MEM_CONSTS_VH
`define EXT_MEM_CONSTS_VH
// register indices (byte address is four times the index)
`define IDX_PAGE        8'h1E
`define IDX_WAIT_FIELDS 8'h28
`define IDX_BANK_CTRL   8'h29
`define IDX_WAIT_CTRL   8'h2B
`define IDX_VEC_PTR     8'h1D
// reset values
`define RST_PAGE        7'h00
`define RST_WAIT_FIELDS 16'h7FFF
`define RST_VEC_PTR     9'h1FF
`define RST_DIV         2'h3
// field positions
`define WF_RANGE_BIT    15
`define WF_IO_HI        14
`define WF_IO_LO        12
`define WF_DHI_HI       11
`define WF_DHI_LO       9
`define WF_PHI_HI       5
`define WF_PHI_LO       3
`define WF_PLO_HI       2
`define WF_PLO_LO       0
`define BC_CONSECUTIVE_SWITCHING_BIT   15
`define BC_DIV_HI       14
`define BC_DIV_LO       13
`define BC_ACKOFF_BIT   12
`define BC_HKEEP_BIT    2
`define BC_DKEEP_BIT    1
// address map
`define ONCHIP_DATA_TOP 16'h7FFF
`define ROM_BASE        16'hC000
`define VEC_OFFSET_W    7
`endif

// *** bench/ext_mem_checker_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module ext_mem_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        acc_req,
  input wire logic [1:0]  acc_space,
  input wire logic [22:0] acc_addr,
  input wire logic        acc_done,
  input wire logic        acc_external,
  input wire logic        acc_onchip_ram,
  input wire logic        memory_strobe_n,
  input wire logic        ready_in,
  input wire logic        output_clock_pin,
  input wire logic        interrupt_ack_output_n,
  input wire logic        host_bus_keeper,
  input wire logic        data_bus_keeper,
  input wire logic        wait_clk_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ************
  // shadow registers
  // ************
  logic [15:0] wf;    // wait field copy
  logic [15:0] bc;    // bank control copy
  logic [3:0]  age;   // cycles since last wf or bc write
  logic [2:0]  cnt;   // cycles since clock rise
  logic        pin_q; // delayed clock pin
  logic        seen;  // one rise seen
  wire wr = psel && penable && pready && pwrite;
  // track writes over the register bus
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wf    <= 16'h7FFF;
      bc    <= 16'hF000;
      age   <= 4'h0;
      cnt   <= 3'h0;
      pin_q <= 1'b0;
      seen  <= 1'b0;
    end else begin
      age   <= (age == 4'hF) ? age : age + 4'h1;
      pin_q <= output_clock_pin;
      seen  <= seen | (output_clock_pin & ~pin_q);
      cnt   <= (output_clock_pin & ~pin_q) ? 3'h1 : ((cnt == 3'h7) ? cnt : cnt + 3'h1);
      if (wr && paddr == 32'h000000A0) begin
        wf  <= pwdata[15:0];
        age <= 4'h0;
      end
      if (wr && paddr == 32'h000000A4) begin
        bc  <= pwdata[15:0];
        age <= 4'h0;
      end
    end
  end
  // ************
  // external access steps
  // ************
  sequence ext_start;
    $rose(acc_req) && acc_space == 2'h1 && acc_addr[15];
  endsequence
  sequence ext_end;
    acc_done && acc_external && !acc_onchip_ram;
  endsequence
  done_ram_a: assert property ($rose(acc_req) && acc_space == 2'h1 && !acc_addr[15] |=> acc_done && acc_onchip_ram)
    else $error("internal data access not done in one cycle");
  ext_done_a: assert property (ext_start |-> ##[2:60] ext_end)
    else $error("upper data access not external");
  strobe_idle_a: assert property (!acc_req |-> memory_strobe_n)
    else $error("strobe active without request");
  ready_hold_a: assert property (!memory_strobe_n && !ready_in |=> !memory_strobe_n)
    else $error("strobe ended while not ready");
  wait_gate_a: assert property (age == 4'hF && wf[8:6] == 3'h0 |-> wait_clk_enable == (wf[14:0] != 15'h0))
    else $error("wait clock gate wrong");
  clk_div_a: assert property ($rose(output_clock_pin) && seen && age == 4'hF && bc[14:13] != 2'h0
    |-> cnt == {1'b0, bc[14:13]} + 3'h1)
    else $error("output clock period wrong");
  ack_off_a: assert property (age == 4'hF && bc[12] |-> interrupt_ack_output_n)
    else $error("acknowledge not suppressed");
  keeper_a: assert property (age == 4'hF |-> host_bus_keeper == bc[2] && data_bus_keeper == bc[1])
    else $error("keeper enable wrong");
  rsvd_zero_a: assert property (pready && !pwrite && paddr == 32'h000000AC |-> prdata[31:1] == 31'h0)
    else $error("wait control reserved bits nonzero");
endmodule
`default_nettype wire

// *** bench/ext_dev_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// external memory that may hold ready low for a number of strobe cycles
module ext_dev_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       memory_strobe_n,
  input  wire logic [3:0] stall,
  output var  logic       ready_in
);
  logic [3:0] cnt;  // strobe cycles seen
  logic       idle; // pattern while not selected
  // count strobe cycles, toggle the released line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= 4'h0;
      idle <= 1'b0;
    end else begin
      cnt  <= memory_strobe_n ? 4'h0 : ((cnt == 4'hF) ? cnt : cnt + 4'h1);
      idle <= ~idle;
    end
  end
  // ready inactive until the stall has run out
  always @* begin
    ready_in = memory_strobe_n ? idle : (cnt >= stall);
  end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin checks++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
  // ************
  // stimulus and observed signals
  // ************
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, acc_req = 0, acc_far = 0;
  logic vec_req = 0, vec_is_reset = 0, ram_overlay_enable = 0, rom_select_input = 1, interrupt_ack_output_in = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, q;
  logic [1:0]  acc_space = 0;
  logic [22:0] acc_addr = 0, ext_addr, vec_addr, ea;
  logic [6:0]  acc_far_page = 0;
  logic [4:0]  vec_num = 0;
  logic [3:0]  stall = 0;
  logic pready, pslverr, ready_in, acc_done, acc_external, acc_onchip_ram, acc_onchip_rom, memory_strobe_n;
  logic output_clock_pin, interrupt_ack_output_n, host_bus_keeper, data_bus_keeper, wait_clk_enable;
  logic err, ex, ram, rom;
  int checks = 0, fail_count = 0, cyc = 0, n, b, i;
  // wait table: fields, multiplier, space, address, expected waits
  logic [15:0] tw[9] = '{16'h0600, 16'h01C0, 16'h5000, 16'h0018, 16'h0018, 16'h8018, 16'h8018, 16'h0600, 16'h0E00};
  logic        tm[9] = '{0, 0, 0, 0, 0, 0, 0, 1, 1};
  logic [1:0]  ts[9] = '{1, 1, 2, 0, 0, 0, 0, 1, 1};
  logic [22:0] ta[9] = '{23'h009000, 23'h009000, 23'h009000, 23'h019000, 23'h011000, 23'h409000, 23'h019000,
                         23'h009000, 23'h009000};
  int          te[9] = '{3, 0, 5, 3, 0, 3, 0, 6, 14};
  ext_mem_wait_bank_paging ext_mem_wait_bank_paging_i (.*);
  ext_dev_model ext_dev_model_i (.*);
  always #12.5 pclk = ~pclk;
  // cut a hang short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  // ************
  // bus and access tasks
  // ************
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= {22'h0, idx, 2'h0}; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input string nm, input logic [7:0] idx, input logic [31:0] e);
    apb(0, idx, 32'h0);
    `CHK(nm, e, q)
  endtask
  task acc(input logic [1:0] sp, input logic [22:0] a, input logic f);
    @(posedge pclk);
    acc_req <= 1; acc_space <= sp; acc_addr <= a; acc_far <= f; acc_far_page <= a[22:16]; n = 0;
    do begin @(posedge pclk); n++; end while (acc_done !== 1'b1);
    ex = acc_external; ram = acc_onchip_ram; rom = acc_onchip_rom; ea = ext_addr;
    acc_req <= 0;
    acc_far <= 0;
  endtask
  task meas(input logic [1:0] sp, input logic [22:0] a, input logic f);
    acc(sp, a, f);
    acc(sp, a, f);
  endtask
  task vec(input logic [4:0] v, input logic r, input logic [22:0] e);
    @(posedge pclk);
    vec_req <= 1; vec_num <= v; vec_is_reset <= r;
    @(posedge pclk);
    vec_req <= 0;
    @(posedge pclk);
    `CHK("vec_addr", e, vec_addr)
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ************
  // test sequence
  // ************
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    rd("program_page_select", 8'h1E, 32'h0);
    rd("wait_state_fields", 8'h28, 32'h7FFF);
    rd("bank_switch_control", 8'h29, 32'hF000);
    rd("wait_state_control", 8'h2B, 32'h0);
    apb(1, 8'h2B, 32'hFFFFFFFF);
    rd("wait_state_control", 8'h2B, 32'h1);
    apb(1, 8'h29, 32'hFFFFFFFF);
    rd("bank_switch_control", 8'h29, 32'hF006);
    apb(1, 8'h1E, 32'hFF);
    rd("program_page_select", 8'h1E, 32'h7F);
    apb(0, 8'h3C, 32'h0);
    `CHK("unmapped", 1'b1, err)
    $display("registers done");
    apb(1, 8'h1E, 32'h0);
    vec(5'h05, 0, 23'h00FF94);
    apb(1, 8'h1D, 32'h5);
    vec(5'h02, 0, 23'h000288);
    vec(5'h00, 1, 23'h00FF80);
    $display("vectors done");
    rom_select_input <= 0;
    acc(0, 23'h00C000, 1);
    `CHK("rom page0", 1'b1, rom)
    acc(0, 23'h03C000, 1);
    `CHK("rom page3", 2'b01, {rom, ex})
    `CHK("ext_addr", 23'h03C000, ea)
    acc(0, 23'h059234, 0);
    `CHK("ext_addr near", 23'h039234, ea)
    rd("program_page_select", 8'h1E, 32'h3);
    ram_overlay_enable <= 1;
    acc(0, 23'h001234, 0);
    `CHK("overlay low", 1'b1, ram)
    acc(0, 23'h009234, 0);
    `CHK("overlay high", 2'b01, {ram, ex})
    ram_overlay_enable <= 0;
    acc(1, 23'h001000, 0);
    `CHK("data low", 1'b1, ram)
    acc(1, 23'h009000, 0);
    `CHK("data high", 1'b1, ex)
    $display("decode done");
    apb(1, 8'h29, 32'h7000);
    apb(1, 8'h28, 32'h0);
    apb(1, 8'h2B, 32'h0);
    meas(1, 23'h009000, 0);
    b = n;
    `CHK("wait gate", 1'b0, wait_clk_enable)
    for (i = 0; i < 9; i++) begin
      apb(1, 8'h28, {16'h0, tw[i]});
      apb(1, 8'h2B, {31'h0, tm[i]});
      meas(ts[i], ta[i], ts[i] == 2'h0);
      `CHK("wait count", b + te[i], n)
    end
    apb(1, 8'h28, 32'h0);
    apb(1, 8'h2B, 32'h0);
    acc(0, 23'h011000, 1);
    acc(1, 23'h009000, 0);
    `CHK("bank swap", b + 1, n)
    apb(1, 8'h29, 32'hF000);
    meas(1, 23'h009000, 0);
    `CHK("consecutive", b + 2, n)
    apb(1, 8'h29, 32'h7000);
    stall <= 4'h5;
    meas(1, 23'h009000, 0);
    `CHK("ready stall", 1'b1, n > b)
    stall <= 4'h0;
    $display("timing done");
    interrupt_ack_output_in <= 1;
    repeat (3) @(posedge pclk);
    `CHK("ack off", 1'b1, interrupt_ack_output_n)
    apb(1, 8'h29, 32'h2006);
    apb(1, 8'h28, 32'h1);
    repeat (20) @(posedge pclk);
    `CHK("ack on", 1'b0, interrupt_ack_output_n)
    `CHK("keepers", 2'b11, {host_bus_keeper, data_bus_keeper})
    `CHK("wait gate on", 1'b1, wait_clk_enable)
    $display("outputs done");
    close_out();
  end
endmodule
bind ext_mem_wait_bank_paging ext_mem_checker ext_mem_checker_i (.*);
`default_nettype wire
